//--- rtl/static_mem_ctrl.sv
// Six-bank static memory controller: selects, wait states, splits, bursts
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Function
// - Six active-low bank selects, one at once
// - Each bank has own timing control register
// - Capture read data one edge before release
// - Release select and address edge after capture
// - Programmable wait count holds bus N cycles
// - Asserted external wait freezes bus state
// - Count and wait both end before continuing
// - Wide request to narrow bank splits accesses
// - Assemble split read, hold requester until taken
// - Active-low byte lane masks during writes
// - Burst steps address bits four and three
// - Per-bank page burst enable selects bursts
// - Little-endian byte order on all banks
// - Bank data path 8, 16 or 32 bits
// - Shared bus programmable 16 or 32 bits
// - DMA handshake, two external channels only
module static_mem_ctrl
    import static_mem_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              sys_rst_in,
    input  wire logic              clk_en_in,
    input  wire logic [REG_AW-1:0] reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [31:0]            reg_rdata_out,
    input  wire logic              req_valid_in,
    input  wire logic              req_write_in,
    input  wire logic [1:0]        req_size_in,
    input  wire logic              req_burst_in,
    input  wire logic [31:0]       req_addr_in,
    input  wire logic [31:0]       req_wdata_in,
    output logic                   req_ready_out,
    output logic                   resp_valid_out,
    input  wire logic              resp_ready_in,
    output logic [31:0]            resp_rdata_out,
    output logic                   resp_error_out,
    output logic [NUM_BANKS-1:0]   bank_select_n_out,
    output logic [EXT_AW-1:0]      ext_addr_out,
    output logic [31:0]            ext_data_out,
    output logic                   ext_data_oe_out,
    input  wire logic [31:0]       ext_data_in,
    output logic                   read_n_out,
    output logic                   write_n_out,
    output logic [3:0]             byte_lane_mask_n_out,
    input  wire logic              ext_wait_n_in,
    input  wire logic [NUM_DMA-1:0] dma_request_in,
    output logic [NUM_DMA-1:0]     dma_request_out,
    output logic [NUM_DMA-1:0]     dma_acknowledge_out,
    input  wire logic [NUM_DMA-1:0] dma_end_of_transfer_in,
    output logic [NUM_DMA-1:0]     dma_end_of_transfer_out
);
    logic [BCR_W-1:0] bank_control_reg [NUM_BANKS];
    logic             bus32_reg;
    bus_state_e       state_reg;
    bus_state_e       state_next;
    logic [2:0]       bank_reg;
    logic             write_reg;
    logic [1:0]       size_reg;
    logic             burst_reg;
    logic             err_reg;
    logic [31:0]      addr_reg;
    logic [31:0]      wdata_reg;
    logic [31:0]      rdata_reg;
    logic [1:0]       part_reg;
    logic [1:0]       beat_reg;

    logic [2:0]       req_bank;
    logic             req_bank_ok;
    logic [BCR_W-1:0] ctrl_req;
    logic [BCR_W-1:0] ctrl_cur;
    logic [1:0]       mw_log;
    logic [1:0]       parts_log;
    logic [1:0]       last_part;
    logic [31:0]      cur_addr;
    logic [1:0]       lane_ofs;
    logic [3:0]       mem_lanes;
    logic [3:0]       req_lanes;
    logic [3:0]       part_lanes;
    logic [4:0]       shamt;
    logic [31:0]      mem_mask32;
    logic [31:0]      rd_mux;
    logic             accept;
    logic             more_beats;
    logic             pins_on;
    logic [WC_W-1:0]  timer_count;
    logic             timer_done;
    logic             wait_active;
    logic [NUM_DMA-1:0] chan_used;

    // Narrow banks and a 16-bit shared bus cap the access width
    function automatic logic [1:0] width_log(input logic [BCR_W-1:0] c,
                                             input logic             b32);
        logic [1:0] w;
        w = c[WIDTH_LSB +: 2];
        if (w == WIDTH_8)
            width_log = 2'h0;
        else if (w == WIDTH_16 || !b32)
            width_log = 2'h1;
        else
            width_log = 2'h2;
    endfunction : width_log

    for (genvar i = 0; i < NUM_BANKS; i++)
    begin : g_bank
        localparam logic [4:0] OFS = 5'(OFS_BANK0 + BANK_STRIDE * i);
        always_ff @(posedge clk_sys_in)
        begin
            if (sys_rst_in)
                bank_control_reg[i] <= BCR_RESET;
            else if (clk_en_in && reg_wr_in && reg_addr_in == OFS)
                bank_control_reg[i] <= reg_wdata_in[BCR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            bus32_reg <= BUS32_RESET;
        else if (clk_en_in && reg_wr_in && reg_addr_in == OFS_BUS_CFG)
            bus32_reg <= reg_wdata_in[0];
    end

    always_comb
    begin
        rd_mux = 32'h0;
        if (reg_addr_in == OFS_BUS_CFG)
            rd_mux[0] = bus32_reg;
        else if (reg_addr_in == OFS_STATUS)
        begin
            rd_mux[STAT_STATE_LSB +: 3] = state_reg;
            rd_mux[STAT_BANK_LSB +: 3]  = bank_reg;
            rd_mux[STAT_WAIT_BIT]       = wait_active;
        end
        else if (reg_addr_in[4:2] <= BANK_LAST && reg_addr_in[1:0] == 2'h0)
            rd_mux[BCR_W-1:0] = bank_control_reg[reg_addr_in[4:2]];
    end

    // Read data only in the cycle after the strobe
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 32'h0;
        else if (clk_en_in)
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
    end

    assign req_bank    = req_addr_in[BANK_SEL_LSB +: 3];
    assign req_bank_ok = (req_bank <= BANK_LAST);
    assign ctrl_req    = bank_control_reg[req_bank_ok ? req_bank : 3'h0];
    assign ctrl_cur    = bank_control_reg[bank_reg];
    assign mw_log      = width_log(ctrl_cur, bus32_reg);
    assign parts_log   = (size_reg > mw_log) ? size_reg - mw_log : 2'h0;
    assign last_part   = (parts_log == 2'h0) ? 2'h0 : (parts_log == 2'h1) ? 2'h1 : 2'h3;
    assign accept      = req_valid_in && req_ready_out && clk_en_in;
    assign more_beats  = burst_reg && !err_reg && beat_reg != BURST_LAST;
    assign timer_count = write_reg ? ctrl_cur[WC2_LSB +: WC_W] : ctrl_cur[WC1_LSB +: WC_W];

    // Parts walk upward from the lowest byte address
    always_comb
    begin
        cur_addr = addr_reg + (32'(part_reg) << mw_log);
        if (burst_reg)
            cur_addr[BURST_LSB +: 2] = beat_reg;
    end

    // Little-endian lane placement of each narrow part
    always_comb
    begin
        lane_ofs   = cur_addr[1:0] & ~(2'((3'h1 << mw_log) - 3'h1));
        // One lane per byte of the width: 1, 2 or 4 lanes
        mem_lanes  = (mw_log == 2'h0) ? 4'h1 : (mw_log == 2'h1) ? 4'h3 : 4'hf;
        req_lanes  = 4'(((size_reg == 2'h0) ? 4'h1 : (size_reg == 2'h1) ? 4'h3 : 4'hf)
                        << addr_reg[1:0]);
        part_lanes = 4'(req_lanes >> lane_ofs) & mem_lanes;
        shamt      = {lane_ofs, 3'b000};
        mem_mask32 = {{8{mem_lanes[3]}}, {8{mem_lanes[2]}},
                      {8{mem_lanes[1]}}, {8{mem_lanes[0]}}};
    end

    assign req_ready_out = (state_reg == ST_IDLE);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (accept)
                    state_next = req_bank_ok ? ST_NEXT : ST_RESP;
            ST_NEXT:
                state_next = ST_ACCESS;
            ST_ACCESS:
                if (timer_done)
                    state_next = ST_HOLD;
            ST_HOLD:
                state_next = (part_reg != last_part) ? ST_NEXT : ST_RESP;
            ST_RESP:
                if (resp_ready_in)
                    state_next = more_beats ? ST_NEXT : ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            state_reg <= ST_IDLE;
        else if (clk_en_in)
            state_reg <= state_next;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            bank_reg  <= 3'h0;
            write_reg <= 1'b0;
            size_reg  <= 2'h0;
            burst_reg <= 1'b0;
            err_reg   <= 1'b0;
            addr_reg  <= 32'h0;
            wdata_reg <= 32'h0;
            rdata_reg <= 32'h0;
            part_reg  <= 2'h0;
            beat_reg  <= 2'h0;
        end
        else if (clk_en_in)
        begin
            if (state_reg == ST_IDLE && accept)
            begin
                bank_reg  <= req_bank_ok ? req_bank : 3'h0;
                write_reg <= req_write_in;
                size_reg  <= req_size_in;
                burst_reg <= req_burst_in && ctrl_req[PBE_BIT] && req_size_in == SIZE_WORD
                             && width_log(ctrl_req, bus32_reg) == SIZE_WORD;
                err_reg   <= !req_bank_ok;
                addr_reg  <= req_addr_in;
                wdata_reg <= req_wdata_in;
                rdata_reg <= 32'h0;
                part_reg  <= 2'h0;
                beat_reg  <= 2'h0;
            end
            else if (state_reg == ST_ACCESS && timer_done && !write_reg)
                rdata_reg <= rdata_reg | ((ext_data_in & mem_mask32) << shamt);
            else if (state_reg == ST_HOLD && part_reg != last_part)
                part_reg <= part_reg + 2'h1;
            else if (state_reg == ST_RESP && resp_ready_in && more_beats)
            begin
                beat_reg  <= beat_reg + 2'h1;
                part_reg  <= 2'h0;
                rdata_reg <= 32'h0;
                wdata_reg <= req_wdata_in;
            end
        end
    end

    assign resp_valid_out = (state_reg == ST_RESP);
    assign resp_rdata_out = rdata_reg;
    assign resp_error_out = err_reg;

    wait_state_timer u_timer (
        .clk_sys_in      (clk_sys_in),
        .sys_rst_in      (sys_rst_in),
        .clk_en_in       (clk_en_in),
        .load_in         (state_reg == ST_NEXT),
        .count_in        (timer_count),
        .ext_wait_n_in   (ext_wait_n_in),
        .done_out        (timer_done),
        .wait_active_out (wait_active)
    );

    // Pins follow the next state so select drops exactly one edge after capture
    assign pins_on = (state_next == ST_ACCESS) || (state_next == ST_HOLD);

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            bank_select_n_out    <= '1;
            ext_addr_out         <= '0;
            ext_data_out         <= 32'h0;
            ext_data_oe_out      <= 1'b0;
            read_n_out           <= 1'b1;
            write_n_out          <= 1'b1;
            byte_lane_mask_n_out <= 4'hf;
        end
        else if (clk_en_in)
        begin
            bank_select_n_out    <= pins_on ? ~(6'h01 << bank_reg) : 6'h3f;
            ext_addr_out         <= pins_on ? cur_addr[EXT_AW-1:0] : '0;
            ext_data_out         <= wdata_reg >> shamt;
            ext_data_oe_out      <= pins_on && write_reg;
            read_n_out           <= !(pins_on && !write_reg);
            write_n_out          <= !(state_next == ST_ACCESS && write_reg);
            byte_lane_mask_n_out <= !pins_on ? 4'hf : write_reg ? ~part_lanes : 4'h0;
        end
    end

    // A channel is live only when some bank claims it
    always_comb
    begin
        chan_used = '0;
        for (int b = 0; b < NUM_BANKS; b++)
            if (bank_control_reg[b][DMA_EN_BIT])
                chan_used[bank_control_reg[b][DMA_CH_BIT]] = 1'b1;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            dma_request_out         <= '0;
            dma_acknowledge_out     <= '0;
            dma_end_of_transfer_out <= '0;
        end
        else if (clk_en_in)
        begin
            dma_request_out         <= dma_request_in & chan_used;
            dma_end_of_transfer_out <= dma_end_of_transfer_in & chan_used;
            dma_acknowledge_out     <= (pins_on && ctrl_cur[DMA_EN_BIT]) ?
                                       2'(2'h1 << ctrl_cur[DMA_CH_BIT]) : 2'h0;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in || !clk_en_in);

    chk_one_bank: assert property ($countones(~bank_select_n_out) <= 1)
        else $error("more than one bank select active");
    chk_capture_edge: assert property (
        (state_reg == ST_ACCESS && timer_done) |=>
        bank_select_n_out != 6'h3f ##1 bank_select_n_out == 6'h3f)
        else $error("select not released one edge after capture");
    chk_release_addr: assert property (
        state_reg == ST_HOLD |=> bank_select_n_out == 6'h3f && ext_addr_out == '0)
        else $error("select or address held after capture");
    chk_wait_count: assert property (
        (state_reg == ST_NEXT && timer_count == 5'd3) |=> (state_reg == ST_ACCESS)[*4])
        else $error("access shorter than programmed wait");
    chk_wait_freeze: assert property (
        (state_reg == ST_ACCESS && wait_active) |=> state_reg == ST_ACCESS && $stable(ext_addr_out))
        else $error("bus moved during external wait");
    chk_both_ended: assert property (
        state_reg == ST_HOLD |-> $past(state_reg) == ST_ACCESS && !$past(wait_active))
        else $error("access ended with wait still active");
    chk_all_parts: assert property (
        (state_reg == ST_RESP && !err_reg) |-> part_reg == last_part)
        else $error("response before all parts done");
    chk_resp_hold: assert property (
        (resp_valid_out && !resp_ready_in) |=> resp_valid_out && $stable(resp_rdata_out))
        else $error("response dropped before taken");
    chk_upper_half: assert property (
        (!write_n_out && size_reg == 2'h1 && mw_log == 2'h2 && addr_reg[1])
        |-> byte_lane_mask_n_out == 4'h3)
        else $error("upper half write mask wrong");
    chk_burst_step: assert property (
        (state_reg == ST_ACCESS && burst_reg) |-> ext_addr_out[BURST_LSB +: 2] == beat_reg)
        else $error("burst address bits off");

    cov_split_read: cover property (state_reg == ST_HOLD && !write_reg && part_reg == 2'h1);
    cov_burst_end: cover property (state_reg == ST_RESP && burst_reg && beat_reg == BURST_LAST);
    cov_wait_stretch: cover property ((state_reg == ST_ACCESS && wait_active) [*3]);
endmodule : static_mem_ctrl

//--- rtl/static_mem_pkg.sv
// Constants, register map and state codes of the static memory controller
package static_mem_pkg;
    localparam int               NUM_BANKS      = 6;
    localparam int               NUM_DMA        = 2;
    localparam int               BCR_W          = 15;
    localparam int               REG_AW         = 5;
    localparam int               EXT_AW         = 26;
    localparam logic [4:0]       OFS_BANK0      = 5'h00;
    localparam logic [4:0]       BANK_STRIDE    = 5'h04;
    localparam logic [4:0]       OFS_BUS_CFG    = 5'h18;
    localparam logic [4:0]       OFS_STATUS     = 5'h1c;
    localparam int               WC_W           = 5;
    localparam int               WC1_LSB        = 0;
    localparam int               WC2_LSB        = 5;
    localparam int               WIDTH_LSB      = 10;
    localparam int               PBE_BIT        = 12;
    localparam int               DMA_EN_BIT     = 13;
    localparam int               DMA_CH_BIT     = 14;
    localparam logic [1:0]       WIDTH_8        = 2'h0;
    localparam logic [1:0]       WIDTH_16       = 2'h1;
    localparam logic [BCR_W-1:0] BCR_RESET      = 15'h0bff;
    localparam logic             BUS32_RESET    = 1'b1;
    localparam int               BANK_SEL_LSB   = 26;
    localparam logic [2:0]       BANK_LAST      = 3'h5;
    localparam int               BURST_LSB      = 3;
    localparam logic [1:0]       BURST_LAST     = 2'h3;
    localparam logic [1:0]       SIZE_WORD      = 2'h2;
    localparam int               STAT_STATE_LSB = 0;
    localparam int               STAT_BANK_LSB  = 4;
    localparam int               STAT_WAIT_BIT  = 7;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ACCESS = 3'b001,
        ST_HOLD   = 3'b010,
        ST_RESP   = 3'b011,
        ST_NEXT   = 3'b100
    } bus_state_e;
endpackage : static_mem_pkg

//--- rtl/wait_state_timer.sv
// Wait-state counter with synchronised external wait input
`timescale 1ns/1ps
module wait_state_timer
    import static_mem_pkg::*;
(
    input  wire logic            clk_sys_in,
    input  wire logic            sys_rst_in,
    input  wire logic            clk_en_in,
    input  wire logic            load_in,
    input  wire logic [WC_W-1:0] count_in,
    input  wire logic            ext_wait_n_in,
    output logic                 done_out,
    output logic                 wait_active_out
);
    logic            wait_meta_reg;
    logic            wait_sync_reg;
    logic [WC_W-1:0] count_reg;

    // Meta stage feeds only the second stage
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            wait_meta_reg <= 1'b1;
            wait_sync_reg <= 1'b1;
        end
        else if (clk_en_in)
        begin
            wait_meta_reg <= ext_wait_n_in;
            wait_sync_reg <= wait_meta_reg;
        end
    end

    // Counts on during external wait, so the later of the two ends it
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            count_reg <= '0;
        else if (clk_en_in)
        begin
            if (load_in)
                count_reg <= count_in;
            else if (count_reg != '0)
                count_reg <= count_reg - 1'b1;
        end
    end

    assign wait_active_out = !wait_sync_reg;
    assign done_out        = (count_reg == '0) && wait_sync_reg && !load_in;

    chk_count_step: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in || !clk_en_in)
        (count_reg != '0 && !load_in) |=> count_reg == $past(count_reg) - 1'b1)
        else $error("wait count did not step down");

    chk_sync_delay: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in || !clk_en_in)
        (!ext_wait_n_in ##1 !ext_wait_n_in) |=> wait_active_out)
        else $error("wait input not seen after two stages");
endmodule : wait_state_timer

//--- bench/ext_sram_model.sv
// Behavioural external static memory with programmable wait stretching
`timescale 1ns/1ps
module ext_sram_model (
    input  wire logic        clk_sys_in,
    input  wire logic [5:0]  select_n_in,
    input  wire logic [25:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        read_n_in,
    input  wire logic        write_n_in,
    input  wire logic [3:0]  mask_n_in,
    input  wire logic [3:0]  wait_len_in,
    output logic [31:0]      rdata_out,
    output logic             ext_wait_n_out
);
    logic [7:0]  mem [0:255];
    logic [31:0] last_reg;
    logic [3:0]  wcnt_reg;
    logic        prev_sel_reg;
    logic        sel;
    logic [7:0]  a;
    assign sel = select_n_in != 6'h3f;
    assign a   = addr_in[7:0];
    // Any address answers, so page bursts are served; released bus shows inverted data
    assign rdata_out = (sel && !read_n_in) ? {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]}
                                           : ~last_reg;
    // Stretch is only ever commanded for two cycles or more
    assign ext_wait_n_out = (wcnt_reg == 4'h0);
    initial
    begin
        last_reg     = 32'h0;
        wcnt_reg     = 4'h0;
        prev_sel_reg = 1'b0;
    end
    always @(posedge clk_sys_in)
    begin
        prev_sel_reg <= sel;
        if (sel && !prev_sel_reg)
            wcnt_reg <= wait_len_in;
        else if (wcnt_reg != 4'h0)
            wcnt_reg <= wcnt_reg - 4'h1;
        if (sel && !read_n_in)
            last_reg <= rdata_out;
        for (int i = 0; i < 4; i++)
            if (sel && !write_n_in && !mask_n_in[i])
                mem[{a[7:2], 2'b00} + 8'(i)] <= wdata_in[8*i +: 8];
    end
endmodule : ext_sram_model

//--- bench/tb.sv
// Self-checking bench: registers, splits, waits, masks and bursts
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb;
    import static_mem_pkg::*;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0, req_write = 0;
    logic req_burst = 0, resp_ready = 0;
    logic [4:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0, req_addr = '0, req_wdata = '0, rdata;
    logic [1:0]  req_size = '0;
    logic [3:0]  wait_len = '0;
    logic [4:0]  wr_mask;
    logic [1:0]  dma_req = '0, dma_eot = '0, ack_seen = '0;
    wire  [1:0]  dma_req_o, dma_eot_o, dma_ack;
    wire         oe;
    wire  [31:0] reg_rdata, resp_rdata, ext_dout, ext_din;
    wire  [25:0] ext_addr;
    wire  [5:0]  sel_n;
    wire  [3:0]  mask_n;
    wire         req_ready, resp_valid, resp_err, read_n, write_n, wait_n;
    logic        err;
    int          n_fail = 0, n_tests = 0, n_parts = 0, cur_len = 0, last_len = 0;
    logic [25:0] addr_log [0:3];
    initial forever #20 clk = ~clk;
    static_mem_ctrl uut (.clk_sys_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .req_valid_in(req_valid), .req_write_in(req_write),
        .req_size_in(req_size), .req_burst_in(req_burst), .req_addr_in(req_addr),
        .req_wdata_in(req_wdata), .req_ready_out(req_ready), .resp_valid_out(resp_valid),
        .resp_ready_in(resp_ready), .resp_rdata_out(resp_rdata), .resp_error_out(resp_err),
        .bank_select_n_out(sel_n), .ext_addr_out(ext_addr), .ext_data_out(ext_dout),
        .ext_data_oe_out(oe), .ext_data_in(ext_din), .read_n_out(read_n), .write_n_out(write_n),
        .byte_lane_mask_n_out(mask_n), .ext_wait_n_in(wait_n), .dma_request_in(dma_req),
        .dma_request_out(dma_req_o), .dma_acknowledge_out(dma_ack),
        .dma_end_of_transfer_in(dma_eot), .dma_end_of_transfer_out(dma_eot_o));
    ext_sram_model mem_model (.clk_sys_in(clk), .select_n_in(sel_n), .addr_in(ext_addr),
        .wdata_in(ext_dout), .read_n_in(read_n), .write_n_in(write_n), .mask_n_in(mask_n),
        .wait_len_in(wait_len), .rdata_out(ext_din), .ext_wait_n_out(wait_n));
    // Part count, select-low length, part addresses and write masks
    always @(negedge clk)
    begin
        if (sel_n != 6'h3f && cur_len == 0)
        begin
            addr_log[n_parts[1:0]] = ext_addr;
            n_parts++;
        end
        if (sel_n != 6'h3f)
            cur_len++;
        else if (cur_len != 0)
        begin
            last_len = cur_len;
            cur_len  = 0;
        end
        if (sel_n != 6'h3f)
            ack_seen = dma_ack;
        if (!write_n)
            wr_mask = {oe, mask_n};
    end
    task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : reg_read
    task automatic request(input logic w, input logic [1:0] sz, input logic b,
                           input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        {req_write, req_size, req_burst, req_addr, req_wdata} <= {w, sz, b, a, d};
        req_valid <= 1'b1;
        @(negedge clk);
        for (int i = 0; i < 50 && !req_ready; i++)
            @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask : request
    task automatic response(output logic [31:0] d, output logic e);
        @(negedge clk);
        for (int i = 0; i < 200 && resp_valid !== 1'b1; i++)
            @(negedge clk);
        d = resp_rdata;
        e = resp_err;
        `CHK(req_ready, 1'b0)
        @(posedge clk);
        resp_ready <= 1'b1;
        @(posedge clk);
        resp_ready <= 1'b0;
    endtask : response
    task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a,
                          input logic [31:0] d);
        n_parts = 0;
        request(w, sz, 1'b0, a, d);
        response(rdata, err);
    endtask : access
    task automatic summarize;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            reg_read(5'(4 * i), rdata);
            `CHK(rdata, 32'h00000bff)
        end
        reg_read(5'h18, rdata);
        `CHK(rdata, 32'h00000001)
        reg_read(5'h02, rdata);
        `CHK(rdata, 32'h00000000)
        // Bank 0 fast 32-bit, bank 1 8-bit, bank 2 paged, bank 3 three waits
        reg_write(5'h00, 32'h800);
        reg_write(5'h04, 32'h000);
        reg_write(5'h08, 32'h1800);
        reg_write(5'h0c, 32'h803);
        reg_read(5'h0c, rdata);
        `CHK(rdata, 32'h00000803)
        access(1'b1, 2'h2, 32'h00000010, 32'h44332211);
        `CHK(wr_mask, 5'h10)
        access(1'b1, 2'h1, 32'h00000012, 32'hbbaa0000);
        `CHK(wr_mask, 5'h13)
        access(1'b0, 2'h2, 32'h00000010, 32'h0);
        `CHK(rdata, 32'hbbaa2211)
        `CHK(last_len, 2)
        access(1'b0, 2'h2, 32'h04000010, 32'h0);
        `CHK(rdata, 32'hbbaa2211)
        `CHK(n_parts, 4)
        access(1'b0, 2'h2, 32'h0c000010, 32'h0);
        `CHK(last_len, 5)
        wait_len <= 4'h8;
        access(1'b0, 2'h2, 32'h0c000010, 32'h0);
        `CHK(rdata, 32'hbbaa2211)
        `CHK(last_len > 9 && last_len < 16, 1'b1)
        wait_len <= 4'h0;
        for (int k = 0; k < 4; k++)
            access(1'b1, 2'h2, 32'h20 + 32'(8 * k), 32'h0a0b0c00 + 32'(k));
        // Request is aligned to a four-beat boundary
        n_parts = 0;
        request(1'b0, 2'h2, 1'b1, 32'h08000020, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            response(rdata, err);
            `CHK(rdata, 32'h0a0b0c00 + 32'(k))
            `CHK(addr_log[k][4:3], 2'(k))
        end
        n_parts = 0;
        request(1'b0, 2'h2, 1'b1, 32'h00000020, 32'h0);
        response(rdata, err);
        `CHK(n_parts, 1)
        `CHK(rdata, 32'h0a0b0c00)
        access(1'b0, 2'h2, 32'h18000000, 32'h0);
        `CHK(err, 1'b1)
        `CHK(n_parts, 0)
        // 16-bit shared bus halves a 32-bit bank
        reg_write(5'h18, 32'h0);
        access(1'b0, 2'h2, 32'h00000010, 32'h0);
        `CHK(rdata, 32'hbbaa2211)
        `CHK(n_parts, 2)
        reg_write(5'h18, 32'h1);
        // Bank 4 claims the second handshake channel only
        reg_write(5'h10, 32'h6800);
        dma_req <= 2'h3;
        dma_eot <= 2'h3;
        @(posedge clk);
        @(negedge clk);
        `CHK(dma_req_o, 2'h2)
        `CHK(dma_eot_o, 2'h2)
        access(1'b0, 2'h2, 32'h10000010, 32'h0);
        `CHK(ack_seen, 2'h2)
        `CHK(rdata, 32'hbbaa2211)
        summarize();
    end
endmodule : tb
